// ==== host_ctrl_regs.svh ====
// Register offsets, field positions and timing counts of the host control bank
`ifndef HOST_CTRL_REGS_SVH
`define HOST_CTRL_REGS_SVH
// ********************
// Indirect offsets
// ********************
`define OFF_CMD 8'h00
`define OFF_STAT 8'h03
`define OFF_GATE 8'h04
`define OFF_EXTCFG 8'h0d
`define OFF_CFG 8'h0f
`define OFF_CHEN_LO 8'h10
`define OFF_CHEN_HI 8'h11
`define OFF_LSB_LO 8'h16
`define OFF_LSB_HI 8'h17
`define OFF_UNDER_LO 8'h18
`define OFF_UNDER_HI 8'h19
`define OFF_OVER_LO 8'h1a
`define OFF_OVER_HI 8'h1b
`define OFF_XADDR0 8'h60
`define OFF_XADDR1 8'h61
`define OFF_XADDR2 8'h62
`define OFF_XDATA 8'h63
`define OFF_SER_STAT 8'h64
`define OFF_SER_RD_LO 8'h65
`define OFF_SER_RA_LO 8'h66
`define OFF_SER_WD_LO 8'h67
`define OFF_SER_RD_HI 8'h68
`define OFF_SER_RA_HI 8'h69
`define OFF_SER_WD_HI 8'h6a
// ********************
// Fields
// ********************
`define CMD_DMA_EN_BIT 3
`define GATE_BIT 4
`define WORD_EXCH_BIT 0
`define HALF_EXCH_BIT 3
`define BYTE_EXCH_BIT 0
`define CHAN_MASK 16'h1f1f
`define TARGET_LAST 6'h14
// ********************
// Timing
// ********************
`define TEST_PERIOD_MS 1000
`define CLK_MHZ 250
`endif

// ==== host_ctrl_pkg.sv ====
// Types shared by the host control bank
package host_ctrl_pkg;
    typedef enum logic [1:0] {
        SER_IDLE = 2'b01,
        SER_BUSY = 2'b10
    } ser_state_t;
endpackage

// ==== channel_lane.sv ====
// One DMA channel lane: single word holding stage, serializer and fault flags
`timescale 1ns/1ps
module channel_lane #(
    parameter int W = 32
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Control
    input wire logic enable,
    input wire logic lsb_first,
    // Word input from DMA
    input wire logic in_valid,
    input wire logic [W-1:0] in_word,
    // Serial out and faults
    output logic bit_out,
    output logic under,
    output logic over
);
    localparam int CW = $clog2(W);
    logic [W-1:0] hold;
    logic [W-1:0] shift;
    logic hold_full;
    logic [CW-1:0] cnt;
    logic [7:0] last;
    logic load;

    assign load = (cnt == CW'(W - 1));
    assign bit_out = lsb_first ? shift[0] : shift[W-1];

    // Disabled lane has its count, stage and flags cleared; shift register and last byte keep their values
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            hold <= '0;
            shift <= '0;
            hold_full <= 1'b0;
            cnt <= '0;
            last <= '0;
            under <= 1'b0;
            over <= 1'b0;
        end else if (!enable) begin
            hold_full <= 1'b0;
            cnt <= '0;
            under <= 1'b0;
            over <= 1'b0;
        end else begin
            cnt <= load ? '0 : cnt + 1'b1;
            if (load && hold_full) begin
                shift <= hold;
                last <= lsb_first ? hold[W-1:W-8] : hold[7:0];
            end else if (load) begin
                shift <= {(W / 8){last}};
                under <= 1'b1;
            end else begin
                shift <= lsb_first ? (shift >> 1) : (shift << 1);
            end
            // A word arriving while the stage is still full is dropped
            if (in_valid && (!hold_full || load)) begin
                hold <= in_word;
                hold_full <= 1'b1;
            end else if (in_valid) begin
                over <= 1'b1;
            end else if (load) begin
                hold_full <= 1'b0;
            end
        end
    end
endmodule

// ==== host_control_register_bank.sv ====
// Host control register bank: command, interrupts, data order, channels, serial master
//
// Function
// - DMA enable gates channels, clear resets all channel counts, stages and faults
// - Command bits 7-4 enable each source
// - Status bits 3-0 show sampled inputs
// - Enabled asserted input raises interrupt; re-enable clears
// - Global gate passes or blocks all
// - Default source is once-per-second test tick
// - Word exchange swaps 32-bit halves
// - Halfword exchange swaps 16-bit halves
// - Byte pair exchange swaps bytes 0/1,2/3
// - Swaps combine; all three reverse bytes
// - Channel enable bits 12-8, 4-0
// - Bit order select picks LSB first
// - Empty FIFO sets underflow, repeats last byte
// - Overrun sets overflow, discards data
// - Faults clear only by disable then enable
// - Extended address from three byte registers
// - Extended data accesses addressed register
// - Serial status shows busy and no-ack
// - Six-bit target select, codes 0-20
// - Read address write, then read fetched data
// - Serial register address pair is read-write
// - Offsets 0x00-0x7F local, above go to ports
// - Serial write data in two byte registers
`timescale 1ns/1ps
`include "host_ctrl_regs.svh"
module host_control_register_bank #(
    parameter int TICK_HALF = `TEST_PERIOD_MS * 1000 * `CLK_MHZ / 2,
    parameter bit TEST_IRQ = 1'b1,
    parameter int CH = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Indirect register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Per-port register window
    output logic port_strobe,
    output logic port_write,
    output logic [4:0] port_index,
    // Interrupt
    input wire logic [3:0] stat_in,
    output logic irq,
    // 64-bit data ordering stream
    input wire logic din_valid,
    input wire logic [63:0] din,
    output logic dout_valid,
    output logic [63:0] dout,
    // DMA channels
    input wire logic [CH-1:0] ch_valid,
    input wire logic [CH*32-1:0] ch_word,
    output logic [CH-1:0] ch_bit,
    output logic [CH-1:0] ch_active,
    // Extended indirect window
    output logic [23:0] ext_addr,
    output logic ext_wr,
    output logic [7:0] ext_wdata,
    input wire logic [7:0] ext_rdata,
    // Serial master engine
    output logic ser_start,
    output logic ser_read,
    output logic [5:0] ser_target,
    output logic [15:0] ser_reg_addr,
    output logic [15:0] ser_wdata,
    input wire logic ser_done,
    input wire logic ser_ack_fail,
    input wire logic [15:0] ser_rdata
);
    localparam logic [CH-1:0] CHMASK = CH'(`CHAN_MASK);
    logic [7:0] cmd;
    logic gate;
    logic word_exchange;
    logic halfword_exchange;
    logic byte_pair_exchange;
    logic [15:0] channel_enable_bits;
    logic [15:0] bit_order_select;
    logic [CH-1:0] fifo_empty_fault;
    logic [CH-1:0] fifo_full_fault;
    logic [3:0] stat_q;
    logic [3:0] pend;
    logic [31:0] tick_cnt;
    logic test_level;
    logic [7:0] ser_rd_addr;
    logic [15:0] ser_result;
    logic target_no_response;
    host_ctrl_pkg::ser_state_t ser_state;
    logic serial_master_active;
    logic [7:0] next_rdata;
    logic [63:0] next_dout;
    logic dma_en;
    logic [3:0] int_en;

    assign dma_en = cmd[`CMD_DMA_EN_BIT];
    assign int_en = cmd[7:4];
    assign serial_master_active = (ser_state == host_ctrl_pkg::SER_BUSY);

    // ************************************************************
    // Control register writes
    // ************************************************************
    // Command, gate and order controls
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cmd <= 8'h00;
            gate <= 1'b0;
            word_exchange <= 1'b0;
            halfword_exchange <= 1'b0;
            byte_pair_exchange <= 1'b0;
        end else if (reg_wr) begin
            case (reg_addr)
                `OFF_CMD: cmd <= {reg_wdata[7:4], reg_wdata[3], 3'h0};
                `OFF_GATE: gate <= reg_wdata[`GATE_BIT];
                `OFF_EXTCFG: word_exchange <= reg_wdata[`WORD_EXCH_BIT];
                `OFF_CFG: begin
                    halfword_exchange <= reg_wdata[`HALF_EXCH_BIT];
                    byte_pair_exchange <= reg_wdata[`BYTE_EXCH_BIT];
                end
                default: ;
            endcase
        end
    end

    // Channel enables and bit order, low byte then high byte
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            channel_enable_bits <= 16'h0000;
            bit_order_select <= 16'h0000;
        end else if (reg_wr) begin
            case (reg_addr)
                `OFF_CHEN_LO: channel_enable_bits[7:0] <= reg_wdata;
                `OFF_CHEN_HI: channel_enable_bits[15:8] <= reg_wdata;
                `OFF_LSB_LO: bit_order_select[7:0] <= reg_wdata;
                `OFF_LSB_HI: bit_order_select[15:8] <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Extended indirect window
    // ************************************************************
    // Address bytes stored in place; data writes pass out as a pulse
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ext_addr <= 24'h000000;
            ext_wr <= 1'b0;
            ext_wdata <= 8'h00;
        end else begin
            ext_wr <= reg_wr && (reg_addr == `OFF_XDATA);
            if (reg_wr) begin
                case (reg_addr)
                    `OFF_XADDR0: ext_addr[7:0] <= reg_wdata;
                    `OFF_XADDR1: ext_addr[15:8] <= reg_wdata;
                    `OFF_XADDR2: ext_addr[23:16] <= reg_wdata;
                    `OFF_XDATA: ext_wdata <= reg_wdata;
                    default: ;
                endcase
            end
        end
    end

    // Accesses above the local space go out to the port blocks
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            port_strobe <= 1'b0;
            port_write <= 1'b0;
            port_index <= 5'h00;
        end else begin
            port_strobe <= (reg_wr || reg_rd) && reg_addr[7];
            port_write <= reg_wr && reg_addr[7];
            port_index <= reg_addr[7:3] - 5'h10;
        end
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    // Test tick toggles once per half second, so a full period is one second
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tick_cnt <= 32'h00000000;
            test_level <= 1'b0;
        end else if (tick_cnt == 32'(TICK_HALF - 1)) begin
            tick_cnt <= 32'h00000000;
            test_level <= ~test_level;
        end else begin
            tick_cnt <= tick_cnt + 32'h00000001;
        end
    end

    // Sample sources; a pending bit drops only while its enable is clear
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            stat_q <= 4'h0;
            pend <= 4'h0;
            irq <= 1'b0;
        end else begin
            stat_q <= stat_in | {3'h0, test_level & TEST_IRQ};
            pend <= int_en & (pend | stat_q);
            irq <= gate && (pend != 4'h0);
        end
    end

    // ************************************************************
    // Data ordering
    // ************************************************************
    // The three exchanges commute, so they are applied in one pass
    always_comb begin
        next_dout = word_exchange ? {din[31:0], din[63:32]} : din;
        if (halfword_exchange) begin
            next_dout = {next_dout[47:32], next_dout[63:48], next_dout[15:0], next_dout[31:16]};
        end
        if (byte_pair_exchange) begin
            next_dout = {next_dout[55:48], next_dout[63:56], next_dout[39:32], next_dout[47:40],
                         next_dout[23:16], next_dout[31:24], next_dout[7:0], next_dout[15:8]};
        end
    end

    // Reordered word is registered together with its valid
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dout_valid <= 1'b0;
            dout <= 64'h0;
        end else begin
            dout_valid <= din_valid;
            if (din_valid) begin
                dout <= next_dout;
            end
        end
    end

    // ************************************************************
    // DMA channels
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < CH; i++) begin : g_ch
            if (CHMASK[i]) begin : g_on
                assign ch_active[i] = dma_en && channel_enable_bits[i];
                channel_lane #(.W(32)) u_lane (
                    .clk_sys(clk_sys),
                    .rstn(rstn),
                    .enable(ch_active[i]),
                    .lsb_first(bit_order_select[i]),
                    .in_valid(ch_valid[i]),
                    .in_word(ch_word[i*32 +: 32]),
                    .bit_out(ch_bit[i]),
                    .under(fifo_empty_fault[i]),
                    .over(fifo_full_fault[i])
                );
            end else begin : g_off
                assign ch_active[i] = 1'b0;
                assign ch_bit[i] = 1'b0;
                assign fifo_empty_fault[i] = 1'b0;
                assign fifo_full_fault[i] = 1'b0;
            end
        end
    endgenerate

    // ************************************************************
    // Serial master front end
    // ************************************************************
    // Writing the read address launches a read; the high write data byte launches a write
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ser_state <= host_ctrl_pkg::SER_IDLE;
            ser_start <= 1'b0;
            ser_read <= 1'b0;
            ser_target <= 6'h00;
            ser_rd_addr <= 8'h00;
            ser_reg_addr <= 16'h0000;
            ser_wdata <= 16'h0000;
            ser_result <= 16'h0000;
            target_no_response <= 1'b0;
        end else begin
            ser_start <= 1'b0;
            case (ser_state)
                host_ctrl_pkg::SER_IDLE: begin
                    if (reg_wr) begin
                        case (reg_addr)
                            `OFF_SER_STAT: begin
                                if (reg_wdata[5:0] <= `TARGET_LAST) begin
                                    ser_target <= reg_wdata[5:0];
                                end
                            end
                            `OFF_SER_RA_LO: ser_reg_addr[7:0] <= reg_wdata;
                            `OFF_SER_RA_HI: ser_reg_addr[15:8] <= reg_wdata;
                            `OFF_SER_WD_LO: ser_wdata[7:0] <= reg_wdata;
                            `OFF_SER_RD_LO: begin
                                ser_rd_addr <= reg_wdata;
                                ser_read <= 1'b1;
                                ser_start <= 1'b1;
                                ser_state <= host_ctrl_pkg::SER_BUSY;
                            end
                            `OFF_SER_WD_HI: begin
                                ser_wdata[15:8] <= reg_wdata;
                                ser_read <= 1'b0;
                                ser_start <= 1'b1;
                                ser_state <= host_ctrl_pkg::SER_BUSY;
                            end
                            default: ;
                        endcase
                    end
                end
                host_ctrl_pkg::SER_BUSY: begin
                    if (ser_done) begin
                        target_no_response <= ser_ack_fail;
                        if (ser_read) begin
                            ser_result <= ser_rdata;
                        end
                        ser_state <= host_ctrl_pkg::SER_IDLE;
                    end
                end
                default: ser_state <= host_ctrl_pkg::SER_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    // Unmapped local offsets read as zero
    always_comb begin
        case (reg_addr)
            `OFF_CMD: next_rdata = cmd;
            `OFF_STAT: next_rdata = {pend, stat_q};
            `OFF_GATE: next_rdata = {3'h0, gate, 4'h0};
            `OFF_EXTCFG: next_rdata = {7'h00, word_exchange};
            `OFF_CFG: next_rdata = {4'h0, halfword_exchange, 2'h0, byte_pair_exchange};
            `OFF_CHEN_LO: next_rdata = channel_enable_bits[7:0];
            `OFF_CHEN_HI: next_rdata = channel_enable_bits[15:8];
            `OFF_LSB_LO: next_rdata = bit_order_select[7:0];
            `OFF_LSB_HI: next_rdata = bit_order_select[15:8];
            `OFF_UNDER_LO: next_rdata = 8'(fifo_empty_fault);
            `OFF_UNDER_HI: next_rdata = 8'(fifo_empty_fault >> 8);
            `OFF_OVER_LO: next_rdata = 8'(fifo_full_fault);
            `OFF_OVER_HI: next_rdata = 8'(fifo_full_fault >> 8);
            `OFF_XADDR0: next_rdata = ext_addr[7:0];
            `OFF_XADDR1: next_rdata = ext_addr[15:8];
            `OFF_XADDR2: next_rdata = ext_addr[23:16];
            `OFF_XDATA: next_rdata = ext_rdata;
            `OFF_SER_STAT: next_rdata = {serial_master_active, target_no_response, ser_target};
            `OFF_SER_RD_LO: next_rdata = ser_result[7:0];
            `OFF_SER_RD_HI: next_rdata = ser_result[15:8];
            `OFF_SER_RA_LO: next_rdata = ser_reg_addr[7:0];
            `OFF_SER_RA_HI: next_rdata = ser_reg_addr[15:8];
            `OFF_SER_WD_LO: next_rdata = ser_wdata[7:0];
            `OFF_SER_WD_HI: next_rdata = ser_wdata[15:8];
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data is registered on the same edge that samples the strobe
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_src0;
        (gate && stat_q[0] && int_en[0]) ##1 (gate && int_en[0]);
    endsequence
    sequence s_rd_launch;
        reg_wr && reg_addr == `OFF_SER_RD_LO && !serial_master_active;
    endsequence

    a_irq_raise: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_src0 |=> irq) else $error("enabled source did not raise irq");
    a_gate_blocks: assert property (@(posedge clk_sys) disable iff (!rstn)
        !gate |=> !irq) else $error("irq passed a closed gate");
    a_pend_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
        !int_en[0] |=> !pend[0]) else $error("pending kept while disabled");
    a_dma_off_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
        !dma_en ##1 !dma_en |-> fifo_empty_fault == '0 && fifo_full_fault == '0)
        else $error("faults survive disabled dma");
    a_swap_none: assert property (@(posedge clk_sys) disable iff (!rstn)
        din_valid && !word_exchange && !halfword_exchange && !byte_pair_exchange |=> dout == $past(din))
        else $error("natural byte order broken");
    a_swap_all: assert property (@(posedge clk_sys) disable iff (!rstn)
        din_valid && word_exchange && halfword_exchange && byte_pair_exchange
        |=> dout == 64'({<<8{$past(din)}})) else $error("full reversal broken");
    a_ser_launch: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_rd_launch |=> ser_start && ser_read && serial_master_active)
        else $error("read did not launch");
    a_ser_ignore: assert property (@(posedge clk_sys) disable iff (!rstn)
        serial_master_active && !ser_done |=> !ser_start) else $error("start while busy");
    a_ser_done: assert property (@(posedge clk_sys) disable iff (!rstn)
        serial_master_active && ser_done |=> !serial_master_active && target_no_response == $past(ser_ack_fail))
        else $error("completion not recorded");
endmodule

// ==== tb_top.sv ====
// Self-checking testbench for the host control register bank
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_fail++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module tb_top;
    // ********************
    // Stimulus and wiring
    // ********************
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, ext_wdata, ext_rdata = 8'h5a;
    logic reg_wr = 1'b0, reg_rd = 1'b0, port_strobe, port_write, irq, din_valid = 1'b0, dout_valid;
    logic [4:0] port_index;
    logic [3:0] stat_in = 4'h0;
    logic [63:0] din = 64'h0706050403020100, dout;
    logic [15:0] ch_valid = 16'h0000, ch_bit, ch_active, ser_reg_addr, ser_wdata, ser_rdata = 16'h0000;
    logic [511:0] ch_word = 512'h0;
    logic [23:0] ext_addr;
    logic ext_wr, ser_start, ser_read, ser_done = 1'b0, ser_ack_fail = 1'b0;
    logic [5:0] ser_target;
    int n_fail = 0;
    int checked = 0;
    logic [7:0] cfg_tab [6] = '{8'h00, 8'h01, 8'h09, 8'h09, 8'h08, 8'h00};
    logic wx_tab [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [63:0] ord_tab [6] = '{64'h0706050403020100, 64'h0607040502030001, 64'h0405060700010203,
                                 64'h0001020304050607, 64'h0504070601000302, 64'h0302010007060504};
    // Tick shortened and test source off so source 0 stays quiet
    host_control_register_bank #(.TICK_HALF(4), .TEST_IRQ(1'b0), .CH(16)) u_host_control_register_bank (
        .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .port_strobe(port_strobe), .port_write(port_write),
        .port_index(port_index), .stat_in(stat_in), .irq(irq), .din_valid(din_valid), .din(din),
        .dout_valid(dout_valid), .dout(dout), .ch_valid(ch_valid), .ch_word(ch_word), .ch_bit(ch_bit),
        .ch_active(ch_active), .ext_addr(ext_addr), .ext_wr(ext_wr), .ext_wdata(ext_wdata),
        .ext_rdata(ext_rdata), .ser_start(ser_start), .ser_read(ser_read), .ser_target(ser_target),
        .ser_reg_addr(ser_reg_addr), .ser_wdata(ser_wdata), .ser_done(ser_done),
        .ser_ack_fail(ser_ack_fail), .ser_rdata(ser_rdata));
    // 250 MHz system clock
    always #2 clk_sys = ~clk_sys;
    // ********************
    // Bus and check tasks
    // ********************
    // One-cycle strobe; the idle edge after it keeps back-to-back calls legal
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Read data lands at the strobe edge, so sample just after it
    task automatic rc(input logic [7:0] a, input logic [7:0] ex);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        `CHK("read data", ex, reg_rdata)
    endtask
    // Bounded wait on the interrupt line
    task automatic wait_irq(input logic ex);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            #1;
            if (irq === ex) return;
        end
        n_fail++;
        final_report();
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ********************
    // Scenarios
    // ********************
    task automatic t_irq();
        stat_in <= 4'h4;
        wr(8'h00, 8'h20);
        wr(8'h04, 8'h10);
        repeat (6) @(posedge clk_sys);
        #1;
        `CHK("irq off", 1'b0, irq)
        stat_in <= 4'h6;
        wait_irq(1'b1);
        rc(8'h03, 8'h26);
        wr(8'h04, 8'h00);
        wait_irq(1'b0);
        rc(8'h00, 8'h20);
        wr(8'h04, 8'h10);
        wait_irq(1'b1);
        stat_in <= 4'h0;
        wr(8'h00, 8'h00);
        wr(8'h00, 8'h20);
        wait_irq(1'b0);
        wr(8'h03, 8'hff);
        rc(8'h03, 8'h00);
        stat_in <= 4'h1;
        wr(8'h00, 8'h10);
        wait_irq(1'b1);
        wr(8'h00, 8'h00);
        stat_in <= 4'h0;
        wait_irq(1'b0);
    endtask
    task automatic t_order();
        for (int k = 0; k < 6; k++) begin
            wr(8'h0d, {7'h00, wx_tab[k]});
            wr(8'h0f, cfg_tab[k]);
            @(posedge clk_sys);
            din_valid <= 1'b1;
            @(posedge clk_sys);
            din_valid <= 1'b0;
            #1;
            `CHK("reordered word", {1'b1, ord_tab[k]}, {dout_valid, dout})
        end
    endtask
    task automatic t_chan();
        int i;
        wr(8'h16, 8'h02);
        wr(8'h10, 8'h1f);
        wr(8'h11, 8'h1f);
        wr(8'h00, 8'h08);
        #1;
        `CHK("active", 16'h1f1f, ch_active)
        // Same word on an MSB-first and an LSB-first lane, so their bit streams mirror
        @(posedge clk_sys);
        ch_word[63:0] <= 64'hffff0000ffff0000;
        ch_valid <= 16'h0003;
        @(posedge clk_sys);
        ch_valid <= 16'h0000;
        for (i = 0; i < 40 && ch_bit[0] !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (ch_bit[0] !== 1'b1) begin
            n_fail++;
            final_report();
        end
        `CHK("first bits", 2'b01, ch_bit[1:0])
        repeat (16) @(posedge clk_sys);
        #1;
        `CHK("middle bits", 2'b10, ch_bit[1:0])
        repeat (16) @(posedge clk_sys);
        #1;
        `CHK("repeated byte", 2'b10, ch_bit[1:0])
        // Three pushes in a row overrun the holding stage whatever the load phase
        @(posedge clk_sys);
        ch_valid <= 16'h0004;
        repeat (3) @(posedge clk_sys);
        ch_valid <= 16'h0000;
        rc(8'h1a, 8'h04);
        repeat (80) @(posedge clk_sys);
        rc(8'h18, 8'h1f);
        rc(8'h19, 8'h1f);
        wr(8'h00, 8'h00);
        #1;
        `CHK("inactive", 16'h0000, ch_active)
        wr(8'h00, 8'h08);
        rc(8'h18, 8'h00);
        rc(8'h1a, 8'h00);
        wr(8'h00, 8'h00);
    endtask
    task automatic t_ext_port();
        wr(8'h60, 8'h34);
        wr(8'h61, 8'h12);
        wr(8'h62, 8'h56);
        #1;
        `CHK("ext addr", 24'h561234, ext_addr)
        wr(8'h63, 8'hc3);
        #1;
        `CHK("ext strobe", 2'b11, {ext_wr, ext_wdata == 8'hc3})
        rc(8'h63, 8'h5a);
        rc(8'h20, 8'h00);
        wr(8'ha0, 8'h01);
        #1;
        `CHK("port access", 7'h64, {port_strobe, port_write, port_index})
    endtask
    // Serial launch, busy window, completion
    task automatic t_serial(input logic [7:0] la, input logic rdk, input logic fl);
        wr(la, 8'haa);
        #1;
        `CHK("launch", {2'b11, rdk}, {ser_start, ser_target == 6'h05, ser_read})
        rc(8'h64, 8'h85);
        wr(8'h64, 8'h07);
        @(posedge clk_sys);
        ser_done <= 1'b1;
        ser_ack_fail <= fl;
        ser_rdata <= 16'hbeef;
        @(posedge clk_sys);
        ser_done <= 1'b0;
        rc(8'h64, {1'b0, fl, 6'h05});
    endtask
    task automatic t_ser();
        wr(8'h64, 8'h05);
        wr(8'h66, 8'h34);
        wr(8'h69, 8'h12);
        rc(8'h69, 8'h12);
        wr(8'h67, 8'h55);
        t_serial(8'h65, 1'b1, 1'b0);
        `CHK("target reg", 16'h1234, ser_reg_addr)
        rc(8'h65, 8'hef);
        rc(8'h68, 8'hbe);
        t_serial(8'h6a, 1'b0, 1'b1);
        `CHK("write data", 16'haa55, ser_wdata)
        wr(8'h64, 8'h15);
        rc(8'h64, 8'h45);
    endtask
    // ********************
    // Main sequence
    // ********************
    initial begin
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        t_irq();
        t_order();
        t_chan();
        t_ext_port();
        t_ser();
        final_report();
    end
endmodule
